// ---- src/rcr_defines.vh ----
`ifndef RCR_DEFINES_VH
`define RCR_DEFINES_VH
// ----------------------------------------
// register location
// ----------------------------------------
`define RCR_SFR_ADDR      8'hef
`define RCR_SFR_PAGE      8'h00
// ----------------------------------------
// bit positions
// ----------------------------------------
`define RCR_BIT_FLASH     6
`define RCR_BIT_CMP       5
`define RCR_BIT_SW        4
`define RCR_BIT_WDT       3
`define RCR_BIT_CLK       2
`define RCR_BIT_POR       1
`define RCR_BIT_PIN       0
// ----------------------------------------
// reset values
// ----------------------------------------
`define RCR_CAUSE_POR     7'h02
`define RCR_RDATA_RST     8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define RCR_CLK_NS        10
`define RCR_HOLD_NS       160
`define RCR_HOLD_CYC      ((`RCR_HOLD_NS + `RCR_CLK_NS - 1) / `RCR_CLK_NS)
`endif

// ---- src/rcr_reset_cause.v ----
`timescale 1ns/100ps
`include "rcr_defines.vh"

module rcr_reset_cause #(
  parameter HOLD_CYCLES = `RCR_HOLD_CYC
) (
  input  wire       i_clk,
  input  wire       i_rst_b,
  input  wire       i_ce,
  input  wire [7:0] i_sfr_addr,
  input  wire [7:0] i_sfr_page,
  input  wire       i_sfr_wr,
  input  wire       i_sfr_rd,
  input  wire [7:0] i_sfr_wdata,
  input  wire       i_pin_rst_b,
  input  wire       i_cmp_out,
  input  wire       i_clk_lost,
  input  wire       i_vdd_low,
  input  wire       i_wdt_ovf,
  input  wire       i_flash_err,
  output reg  [7:0] o_sfr_rdata,
  output reg        o_sys_rst_b,
  output reg        o_cmp_rst_en,
  output reg        o_clk_loss_en,
  output reg        o_vdd_mon_sel
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_HOLD = 2'h1;
  localparam [1:0] ST_PIN  = 2'h2;
  localparam [7:0] HOLD_LD = HOLD_CYCLES[7:0];

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [7:0] cnt_q;
  reg  [7:0] cnt_d;
  reg  [6:0] cause_q;
  reg  [6:0] cause_d;
  reg  [6:0] trig;
  wire       hit;
  wire       wr_hit;
  wire       sw_force;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  function rcr_match;
    input [7:0] addr;
    input [7:0] page;
    begin
      rcr_match = (addr == `RCR_SFR_ADDR) && (page == `RCR_SFR_PAGE);
    end
  endfunction

  assign hit      = rcr_match(i_sfr_addr, i_sfr_page);
  assign wr_hit   = hit && i_sfr_wr && (state_q == ST_RUN);
  assign sw_force = wr_hit && i_sfr_wdata[`RCR_BIT_SW];

  // one-hot cause from the highest-priority source; power-on outranks all
  function [6:0] rcr_pick;
    input [6:0] t;
    begin
      rcr_pick = 7'h00;
      if (t[`RCR_BIT_POR]) begin
        rcr_pick[`RCR_BIT_POR] = 1'b1;
      end else if (t[`RCR_BIT_PIN]) begin
        rcr_pick[`RCR_BIT_PIN] = 1'b1;
      end else if (t[`RCR_BIT_CLK]) begin
        rcr_pick[`RCR_BIT_CLK] = 1'b1;
      end else if (t[`RCR_BIT_FLASH]) begin
        rcr_pick[`RCR_BIT_FLASH] = 1'b1;
      end else if (t[`RCR_BIT_WDT]) begin
        rcr_pick[`RCR_BIT_WDT] = 1'b1;
      end else if (t[`RCR_BIT_CMP]) begin
        rcr_pick[`RCR_BIT_CMP] = 1'b1;
      end else if (t[`RCR_BIT_SW]) begin
        rcr_pick[`RCR_BIT_SW] = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  always @* begin
    trig = 7'h00;
    trig[`RCR_BIT_FLASH] = i_flash_err;
    trig[`RCR_BIT_CMP]   = o_cmp_rst_en && !i_cmp_out;
    trig[`RCR_BIT_SW]    = sw_force;
    trig[`RCR_BIT_WDT]   = i_wdt_ovf;
    trig[`RCR_BIT_CLK]   = o_clk_loss_en && i_clk_lost;
    trig[`RCR_BIT_POR]   = o_vdd_mon_sel && i_vdd_low;
    trig[`RCR_BIT_PIN]   = !i_pin_rst_b;
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    cause_d = cause_q;
    case (state_q)
      ST_RUN: begin
        if (trig != 7'h00) begin
          cause_d = rcr_pick(trig);
          cnt_d   = HOLD_LD;
          state_d = trig[`RCR_BIT_PIN] && !trig[`RCR_BIT_POR] ? ST_PIN : ST_HOLD;
        end
      end
      ST_PIN: begin
        // the pin flag is set on entry; the hold count starts only on release of the pin
        if (i_pin_rst_b) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // sources firing during the hold are dropped, the first cause wins
        // a pin still held low re-enters reset on the first run cycle
        if (cnt_q <= 8'h01) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = ST_HOLD;
        cnt_d   = HOLD_LD;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= ST_HOLD;
      cnt_q   <= HOLD_LD;
      cause_q <= `RCR_CAUSE_POR;
    end else if (i_ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------
  // core reset
  // ----------------------------------------
  // only the core reset is driven, the pin stays the outside's
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_sys_rst_b <= 1'b0;
    end else if (i_ce) begin
      o_sys_rst_b <= (state_d == ST_RUN);
    end
  end

  // ----------------------------------------
  // source enables
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_cmp_rst_en  <= 1'b0;
      o_clk_loss_en <= 1'b0;
      o_vdd_mon_sel <= 1'b0;
    end else if (i_ce) begin
      if (state_d != ST_RUN) begin
        // every reset disarms the sources that software arms
        o_cmp_rst_en  <= 1'b0;
        o_clk_loss_en <= 1'b0;
        o_vdd_mon_sel <= 1'b0;
      end else if (wr_hit) begin
        // plain write: read-back flags would re-arm sources
        o_cmp_rst_en  <= i_sfr_wdata[`RCR_BIT_CMP];
        o_clk_loss_en <= i_sfr_wdata[`RCR_BIT_CLK];
        o_vdd_mon_sel <= i_sfr_wdata[`RCR_BIT_POR];
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // a read answers for one cycle only, so an idle bus reads zero
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_sfr_rdata <= `RCR_RDATA_RST;
    end else if (i_ce) begin
      if (hit && i_sfr_rd) begin
        o_sfr_rdata <= {1'b0, cause_q};
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

endmodule // rcr_reset_cause

// ---- sim/rcr_props.sv ----
`timescale 1ns/100ps
module rcr_props (
  input wire       i_clk,
  input wire       i_rst_b,
  input wire       i_ce,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_page,
  input wire       i_sfr_wr,
  input wire       i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  input wire       i_pin_rst_b,
  input wire       i_cmp_out,
  input wire       i_clk_lost,
  input wire       i_wdt_ovf,
  input wire [7:0] o_sfr_rdata,
  input wire       o_sys_rst_b,
  input wire       o_cmp_rst_en,
  input wire       o_clk_loss_en,
  input wire       o_vdd_mon_sel
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire hit = i_ce && i_sfr_addr == 8'hef && i_sfr_page == 8'h00;
  // writes only count while the core runs
  wire wr  = hit && i_sfr_wr && o_sys_rst_b;
  a_read_bit7: assert property (hit && i_sfr_rd |=> !o_sfr_rdata[7])
    else $error("bit 7 read back as one");
  a_miss_zero: assert property (i_ce && i_sfr_rd && !hit |=> o_sfr_rdata == 8'h00)
    else $error("read outside the register gave data");
  a_idle_zero: assert property (i_ce && !i_sfr_rd |=> o_sfr_rdata == 8'h00)
    else $error("idle read data not zero");
  a_sw_force: assert property (wr && i_sfr_wdata[4] |=> !o_sys_rst_b)
    else $error("software write did not reset");
  a_cmp_arm: assert property (wr |=> o_cmp_rst_en == $past(i_sfr_wdata[5]))
    else $error("comparator arm wrong");
  a_clk_arm: assert property (wr |=> o_clk_loss_en == $past(i_sfr_wdata[2]))
    else $error("clock-loss arm wrong");
  a_vdd_select: assert property (wr |=> o_vdd_mon_sel == $past(i_sfr_wdata[1]))
    else $error("supply select wrong");
  a_pin_reset: assert property (i_ce && !i_pin_rst_b |=> !o_sys_rst_b)
    else $error("pin low did not reset");
  a_cmp_trig: assert property (i_ce && o_cmp_rst_en && !i_cmp_out |=> !o_sys_rst_b)
    else $error("armed comparator did not reset");
  a_clk_trig: assert property (i_ce && o_clk_loss_en && i_clk_lost |=> !o_sys_rst_b)
    else $error("armed clock loss did not reset");
  a_wdt_trig: assert property (i_ce && i_wdt_ovf |=> !o_sys_rst_b)
    else $error("watchdog did not reset");
  a_reset_disarm: assert property (!o_sys_rst_b |-> !o_cmp_rst_en && !o_clk_loss_en && !o_vdd_mon_sel)
    else $error("source armed during reset");
  a_ce_freeze: assert property (!i_ce |=> $stable(o_sys_rst_b) && $stable(o_sfr_rdata))
    else $error("outputs moved with clock enable low");
endmodule // rcr_props
bind rcr_reset_cause rcr_props i_rcr_props (.*);

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic i_clk = 0, i_rst_b = 0, i_ce = 1, i_sfr_wr = 0, i_sfr_rd = 0;
  logic [7:0] i_sfr_addr = 8'hef, i_sfr_page = 8'h00, i_sfr_wdata = 8'h00;
  logic i_pin_rst_b = 1, i_cmp_out = 1, i_clk_lost = 0, i_vdd_low = 0;
  logic i_wdt_ovf = 0, i_flash_err = 0;
  logic [7:0] o_sfr_rdata;
  logic o_sys_rst_b, o_cmp_rst_en, o_clk_loss_en, o_vdd_mon_sel;
  int errors = 0, checks_done = 0;
  rcr_reset_cause #(.HOLD_CYCLES(2)) i_rcr_reset_cause (.*);
  initial forever #5 i_clk = ~i_clk;
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // plain byte writes only, never read-modify-write
  task wr(input logic [7:0] d);
    @(negedge i_clk) i_sfr_wdata = d;
    i_sfr_wr = 1;
    @(negedge i_clk) i_sfr_wr = 0;
  endtask
  task rd(input logic [7:0] p, input logic [7:0] e);
    @(negedge i_clk) i_sfr_page = p;
    i_sfr_rd = 1;
    @(negedge i_clk) chk(o_sfr_rdata, e);
    i_sfr_rd = 0;
    i_sfr_page = 8'h00;
  endtask
  task wait_run;
    repeat (40) if (o_sys_rst_b !== 1'b1) @(negedge i_clk);
  endtask
  // one reset source per call; the flag of that source alone must remain
  task trig(input int k);
    case (k)
      6: i_flash_err = 1;
      5: begin
        wr(8'h20);
        chk(o_cmp_rst_en, 1);
        i_cmp_out = 0;
      end
      4: wr(8'h10);
      3: i_wdt_ovf = 1;
      2: begin
        wr(8'h04);
        chk(o_clk_loss_en, 1);
        i_clk_lost = 1;
      end
      1: begin
        wr(8'h02);
        chk(o_vdd_mon_sel, 1);
        i_vdd_low = 1;
      end
      default: i_pin_rst_b = 0;
    endcase
    @(negedge i_clk) {i_flash_err, i_wdt_ovf, i_clk_lost, i_vdd_low} = 4'h0;
    i_cmp_out = 1;
    i_pin_rst_b = 1;
    chk(o_sys_rst_b, 0);
    wait_run;
    rd(8'h00, 8'h01 << k);
    chk({o_cmp_rst_en, o_clk_loss_en, o_vdd_mon_sel}, 0);
    $display("test cause %0d done", k);
  endtask
  // read-only and unused bits written as one change nothing
  task ro_bits;
    wr(8'hc9);
    chk(o_sys_rst_b, 1);
    chk({o_cmp_rst_en, o_clk_loss_en, o_vdd_mon_sel}, 0);
    rd(8'h00, 8'h02);
    $display("test read-only bits done");
  endtask
  // clock enable low freezes writes and sources alike
  task ce_hold;
    @(negedge i_clk) i_ce = 0;
    wr(8'h04);
    i_wdt_ovf = 1;
    @(negedge i_clk) chk(o_clk_loss_en, 0);
    chk(o_sys_rst_b, 1);
    i_wdt_ovf = 0;
    i_ce = 1;
    @(negedge i_clk) chk(o_sys_rst_b, 1);
    $display("test clock enable done");
  endtask
  // a write while the core is held in reset is refused
  task refuse_in_reset;
    wr(8'h10);
    wr(8'h24);
    wait_run;
    chk({o_cmp_rst_en, o_clk_loss_en}, 0);
    rd(8'h00, 8'h10);
    $display("test refused write done");
  endtask
  // a second power-on reset in mid-run
  task reset_again;
    wr(8'h20);
    @(negedge i_clk) i_rst_b = 0;
    repeat (5) @(negedge i_clk);
    i_rst_b = 1;
    chk(o_sys_rst_b, 0);
    chk(o_cmp_rst_en, 0);
    wait_run;
    rd(8'h00, 8'h02);
    $display("test second reset done");
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000 errors++;
    summarize;
  end
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_b = 1;
    wait_run;
    rd(8'h00, 8'h02);
    rd(8'h01, 8'h00);
    ro_bits;
    // disarm by plain write, then a lost clock must be ignored
    wr(8'h04);
    wr(8'h00);
    @(negedge i_clk) i_clk_lost = 1;
    @(negedge i_clk) chk(o_sys_rst_b, 1);
    i_clk_lost = 0;
    $display("test disarm done");
    ce_hold;
    for (int k = 6; k >= 0; k--) trig(k);
    refuse_in_reset;
    reset_again;
    summarize;
  end
endmodule // tb_top
